// file: bench/ppc_pins.sv
// Purpose: pins and board outside the port
// Assumes: bench may drive any undriven pin through ext_en
// Notes: a floating pin toggles so a stale level never passes
`timescale 1ns/1ps
module ppc_pins (
    input wire logic clock,
    input wire ppc_pkg::ppc_pad_s pad,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] pin_in
);
    logic tog = 1'b0;
    always @(posedge clock) tog <= ~tog;
    assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_en & ext_val)
        | (~pad.oe & ~ext_en & pad.pull_on & ~pad.pull_down)
        | (~pad.oe & ~ext_en & ~pad.pull_on & {16{tog}});
endmodule : ppc_pins

// file: bench/tb_ppc_port.sv
// Purpose: self-checking bench for the analog-shared port
// Assumes: inputs change on the falling edge
// Notes: rc_tick stands in for the stop-mode filter clock
`timescale 1ns/1ps
module tb_ppc_port;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic stop_mode = 1'b0;
    logic rc_tick = 1'b0;
    logic cfg_we = 1'b0;
    ppc_pkg::ppc_cfg_s cfg = '0;
    logic [15:0] en_we = '0, en_wd = '0, clr = '0, own = '0, pdir = '0, pout = '0;
    logic ana = 1'b0;
    logic [15:0] cdie = 16'hFFFF, ext_en = '0, ext_val = '0, pin_in, data_read, input_read, ens, flags;
    ppc_pkg::ppc_pad_s pad;
    logic irq, wake, rc_run;
    int errors = 0, n_compared = 0, cyc = 0;
    ppc_port dut (.clock(clock), .reset_n(reset_n), .stop_mode(stop_mode), .rc_tick(rc_tick),
        .cfg_we(cfg_we), .cfg_wdata(cfg), .edge_event_enable_we(en_we), .edge_event_enable_wdata(en_wd),
        .edge_event_flag_clear(clr), .periph_own(own), .periph_dir(pdir), .periph_out(pout),
        .analog_enable(ana), .converter_digital_input_enable(cdie), .pin_in(pin_in), .pad(pad),
        .data_read(data_read), .input_read(input_read), .analog_port_edge_enables(ens),
        .analog_port_edge_flags(flags), .irq_request(irq), .wake_request(wake), .rc_osc_run(rc_run));
    ppc_pins pins (.clock(clock), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    initial forever #2 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        // generous: the whole sequence needs under two hundred cycles
        if (cyc == 5000)
        begin
            errors++;
            close_out();
        end
    end
    task automatic close_out;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc_n
    task automatic set_cfg(input logic [15:0] d, o, r, p, s);
        cfg = {d, o, r, p, s, 16'h0000};
        cfg_we = 1'b1;
        cyc_n(1);
        cfg_we = 1'b0;
        // pad one edge, pin path three edges
        cyc_n(4);
    endtask : set_cfg
    task automatic t_reset;
        cyc_n(20);
        chk("oe", 16'h0000, pad.oe);
        chk("reduced", 16'h0000, pad.reduced);
        reset_n = 1'b1;
        cyc_n(2);
        chk("pull", ppc_pkg::PPC_PULL_EN_RST_AD, pad.pull_on);
        chk("enables", 16'h0000, ens);
        chk("flags", 16'h0000, flags);
        chk("irq", 16'h0000, {15'h0000, irq});
    endtask : t_reset
    task automatic t_gpio;
        set_cfg(16'h00FF, 16'h00A5, 16'h0F0F, 16'hFFFF, 16'h3333);
        chk("oe", 16'h00FF, pad.oe);
        chk("out", 16'h00A5, pad.out & pad.oe);
        chk("reduced", 16'h000F, pad.reduced);
        chk("pull", 16'hFF00, pad.pull_on);
        chk("pulldown", 16'h3300, pad.pull_down & pad.pull_on);
        chk("data", 16'hCCA5, data_read);
        chk("input", 16'hCCA5, input_read);
        set_cfg(16'h0000, 16'h00A5, 16'h0F0F, 16'hFFFF, 16'h3333);
        chk("data turn", 16'hCCCC, data_read);
        chk("reduced in", 16'h0000, pad.reduced);
    endtask : t_gpio
    task automatic t_periph;
        own = 16'h000F;
        pdir = 16'h0005;
        pout = 16'h000F;
        cyc_n(2);
        chk("oe periph", 16'h0005, pad.oe);
        chk("out periph", 16'h0005, pad.out & pad.oe);
        own = 16'h0000;
    endtask : t_periph
    task automatic t_analog;
        set_cfg(16'h00FF, 16'h00A5, 16'h0000, 16'h0000, 16'h0000);
        ana = 1'b1;
        cyc_n(4);
        chk("oe analog", 16'h0000, pad.oe);
        chk("input analog", 16'hFFFF, input_read);
        chk("data analog", 16'hFFA5, data_read);
        ana = 1'b0;
    endtask : t_analog
    task automatic pulse(input int n);
        ext_val = 16'hFFFE;
        cyc_n(n);
        ext_val = 16'hFFFD;
        cyc_n(12);
    endtask : pulse
    task automatic t_edge;
        // pin 0 falling, pin 1 rising
        set_cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002);
        ext_en = 16'hFFFF;
        // all pins passive, then wipe flags left by earlier scenarios
        ext_val = 16'hFFFD;
        cyc_n(8);
        clr = 16'hFFFF;
        cyc_n(1);
        clr = 16'h0000;
        cyc_n(1);
        chk("flags wiped", 16'h0000, flags);
        en_we = 16'hFFFF;
        en_wd = 16'h0003;
        cyc_n(1);
        en_we = 16'h0000;
        stop_mode = 1'b1;
        cyc_n(8);
        chk("rc run", 16'h0001, {15'h0000, rc_run});
        stop_mode = 1'b0;
        chk("enables", 16'h0003, ens);
        pulse(3);
        chk("glitch", 16'h0000, flags);
        pulse(4);
        chk("flags", 16'h0003, flags);
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("wake", 16'h0001, {15'h0000, wake});
        stop_mode = 1'b1;
        cyc_n(1);
        chk("rc idle", 16'h0000, {15'h0000, rc_run});
        stop_mode = 1'b0;
        clr = 16'h0001;
        cyc_n(1);
        chk("flag kept", 16'h0002, flags);
        clr = 16'h0002;
        cyc_n(1);
        clr = 16'h0000;
        chk("flags clr", 16'h0000, flags);
        chk("irq clr", 16'h0000, {15'h0000, irq});
    endtask : t_edge
    task automatic t_stop;
        // without rc ticks the filter holds, so even a long pulse goes unseen
        stop_mode = 1'b1;
        pulse(8);
        chk("stop frozen", 16'h0000, flags);
        chk("rc stop", 16'h0001, {15'h0000, rc_run});
        rc_tick = 1'b1;
        pulse(4);
        chk("stop flags", 16'h0003, flags);
        chk("stop wake", 16'h0001, {15'h0000, wake});
        rc_tick = 1'b0;
        stop_mode = 1'b0;
    endtask : t_stop
    initial
    begin
        t_reset();
        t_gpio();
        t_periph();
        t_analog();
        t_edge();
        t_stop();
        close_out();
    end
endmodule : tb_ppc_port

// file: rtl/ppc_pkg.sv
// Purpose: shared constants and carriers for the port pin configuration block
// Assumes: one bus clock at 250 MHz, asynchronous active-low reset
// Notes: pin counts per port are fixed
package ppc_pkg;
    localparam int PPC_AD_PINS = 16;
    localparam int PPC_GP_PINS = 8;
    localparam int PPC_FILT_SAMPLES = 4;
    localparam logic [2:0] PPC_CNT_MAX = 3'h4;
    localparam logic [2:0] PPC_CNT_ZERO = 3'h0;
    localparam int PPC_SYNC_STAGES = 2;
    // reset values: port M upper nibble and port S pulled up, all others hi-z
    localparam logic [7:0] PPC_PULL_EN_RST_M = 8'hF0;
    localparam logic [7:0] PPC_PULL_EN_RST_S = 8'hFF;
    localparam logic [7:0] PPC_PULL_EN_RST_OTHER = 8'h00;
    localparam logic [15:0] PPC_PULL_EN_RST_AD = 16'h0000;
    localparam logic [15:0] PPC_ZERO16 = 16'h0000;
    localparam logic [15:0] PPC_ONES16 = 16'hFFFF;

    // per-pin pad drive bundle
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] reduced;
        logic [15:0] pull_on;
        logic [15:0] pull_down;
    } ppc_pad_s;

    // per-pin software configuration bundle
    typedef struct packed {
        logic [15:0] dir;
        logic [15:0] out_val;
        logic [15:0] drive_strength_reduce_bit;
        logic [15:0] pull_device_on_bit;
        logic [15:0] polarity_choice_bit;
        logic [15:0] wired_or;
    } ppc_cfg_s;
endpackage : ppc_pkg

// file: rtl/ppc_port.sv
// Purpose: one 16-pin analog-shared general-purpose port with filtered edge interrupts
// Assumes: config bits are loaded through write strobes; pins reach us unsynchronised
// Notes: narrower ports use this block with unused upper pins; the pin-interrupt path
//        is present only when HAS_IRQ is set (analog-shared port)
// Behaviour
// - direction zero: pin is input, undriven
// - direction one: drive output value, strength select
// - peripheral ownership overrides direction bit
// - analog enable: outputs off, inputs read one
// - reduced drive only matters on outputs
// - pull only on inputs or wired-or outputs
// - polarity zero pull-up, one pull-down
// - polarity zero falling edge, one rising
// - pin interrupts only on analog-shared port
// - all registers except data_read and input_read reset asynchronously
// - reset: inputs, full drive, interrupts off
// - reset pull-ups on M upper, port S
// - sixteen edge pins, one shared request
// - request when any flag and enable set
// - edge interrupt wakes from stop or wait
// - interrupts on inputs need converter input enable
// - edge needs four passive then four active
// - pulses three clocks ignored, four accepted
// - filter on bus clock, RC clock in stop
// - RC runs in stop while any pin enabled, flag clear
// - data read: pin for inputs, latch for outputs
// - read settles within four cycles after turnaround
`timescale 1ns/1ps
module ppc_port #(
    parameter logic [15:0] PULL_EN_RESET = ppc_pkg::PPC_PULL_EN_RST_AD,
    parameter bit HAS_IRQ = 1'b1
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic stop_mode,
    input wire logic rc_tick,
    input wire logic cfg_we,
    input wire ppc_pkg::ppc_cfg_s cfg_wdata,
    input wire logic [15:0] edge_event_enable_we,
    input wire logic [15:0] edge_event_enable_wdata,
    input wire logic [15:0] edge_event_flag_clear,
    input wire logic [15:0] periph_own,
    input wire logic [15:0] periph_dir,
    input wire logic [15:0] periph_out,
    input wire logic analog_enable,
    input wire logic [15:0] converter_digital_input_enable,
    input wire logic [15:0] pin_in,
    output ppc_pkg::ppc_pad_s pad,
    output logic [15:0] data_read,
    output logic [15:0] input_read,
    output logic [15:0] analog_port_edge_enables,
    output logic [15:0] analog_port_edge_flags,
    output logic irq_request,
    output logic wake_request,
    output logic rc_osc_run
);
    ppc_pkg::ppc_cfg_s cfg;
    logic [15:0] sync_a;
    logic [15:0] sync_b;
    logic [15:0] eff_dir;
    logic [15:0] eff_out;
    logic [15:0] dig_in;
    logic [15:0] pull_allow;
    logic [15:0] rc_want;
    logic filt_tick;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg <= '0;
            cfg.pull_device_on_bit <= PULL_EN_RESET;
        end
        else if (cfg_we)
        begin
            cfg <= cfg_wdata;
        end
    end

    // two-stage synchroniser; the first stage feeds nothing else
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_a <= ppc_pkg::PPC_ZERO16;
            sync_b <= ppc_pkg::PPC_ZERO16;
        end
        else
        begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    assign eff_dir = (periph_own & periph_dir) | (~periph_own & cfg.dir);
    assign eff_out = (periph_own & periph_out) | (~periph_own & cfg.out_val);
    // analog mode forces the digital input path high so stray levels cannot flag edges
    assign dig_in = analog_enable ? ppc_pkg::PPC_ONES16 : sync_b;
    // one gate for both pull outputs, so pull-up and pull-down can never disagree on when to act
    assign pull_allow = cfg.pull_device_on_bit & (~eff_dir | cfg.wired_or);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pad <= '0;
        end
        else
        begin
            pad.oe <= analog_enable ? ppc_pkg::PPC_ZERO16 : eff_dir;
            pad.out <= eff_out & eff_dir;
            pad.reduced <= cfg.drive_strength_reduce_bit & eff_dir;
            pad.pull_on <= pull_allow;
            pad.pull_down <= cfg.polarity_choice_bit & pull_allow;
            data_read <= (cfg.dir & cfg.out_val) | (~cfg.dir & dig_in);
            input_read <= dig_in;
        end
    end

    // filter ticks every bus clock in run/wait; stop uses the rc enable instead
    assign filt_tick = stop_mode ? rc_tick : 1'b1;

    genvar g;
    generate
        if (HAS_IRQ)
        begin : g_irq
            for (g = 0; g < ppc_pkg::PPC_AD_PINS; g++)
            begin : g_pin
                logic [2:0] cnt;
                logic armed;
                logic enable;
                logic flag;
                logic active_lvl;
                logic pin_src;
                logic valid_edge;
                // input use needs the converter digital input path; outputs see their own level
                assign pin_src = eff_dir[g] ? eff_out[g] : (dig_in[g] & converter_digital_input_enable[g]);
                assign active_lvl = (pin_src == cfg.polarity_choice_bit[g]);
                assign valid_edge = filt_tick && armed && active_lvl && (cnt == ppc_pkg::PPC_CNT_MAX - 3'h1);
                always_ff @(posedge clock or negedge reset_n)
                begin
                    if (!reset_n)
                    begin
                        cnt <= ppc_pkg::PPC_CNT_ZERO;
                        armed <= 1'b0;
                    end
                    else if (filt_tick)
                    begin
                        if (!armed)
                        begin
                            // count passive samples until four in a row arm the filter
                            cnt <= active_lvl ? ppc_pkg::PPC_CNT_ZERO : cnt + 3'h1;
                            if (!active_lvl && cnt == ppc_pkg::PPC_CNT_MAX - 3'h1)
                            begin
                                armed <= 1'b1;
                                cnt <= ppc_pkg::PPC_CNT_ZERO;
                            end
                        end
                        else if (!active_lvl)
                        begin
                            cnt <= ppc_pkg::PPC_CNT_ZERO;
                        end
                        else if (cnt == ppc_pkg::PPC_CNT_MAX - 3'h1)
                        begin
                            armed <= 1'b0;
                            cnt <= ppc_pkg::PPC_CNT_ZERO;
                        end
                        else
                        begin
                            cnt <= cnt + 3'h1;
                        end
                    end
                end
                always_ff @(posedge clock or negedge reset_n)
                begin
                    if (!reset_n)
                    begin
                        enable <= 1'b0;
                        flag <= 1'b0;
                    end
                    else
                    begin
                        if (edge_event_enable_we[g])
                        begin
                            enable <= edge_event_enable_wdata[g];
                        end
                        // set wins over a same-cycle clear
                        flag <= valid_edge | (flag & ~edge_event_flag_clear[g]);
                    end
                end
                assign analog_port_edge_enables[g] = enable;
                assign analog_port_edge_flags[g] = flag;
                assign rc_want[g] = enable && !flag && (cnt <= ppc_pkg::PPC_CNT_MAX);
            end
        end
        else
        begin : g_noirq
            assign analog_port_edge_enables = ppc_pkg::PPC_ZERO16;
            assign analog_port_edge_flags = ppc_pkg::PPC_ZERO16;
            assign rc_want = ppc_pkg::PPC_ZERO16;
        end
    endgenerate

    assign irq_request = |(analog_port_edge_flags & analog_port_edge_enables);
    assign wake_request = irq_request;
    assign rc_osc_run = stop_mode && (|rc_want);

    AST_PUSH_PULL_NO_PULL: assert property (@(posedge clock) disable iff (!reset_n)
        (cfg.dir[0] && !periph_own[0] && !cfg.wired_or[0] && !cfg_we) |=> !pad.pull_on[0])
        else $error("pull active on push-pull output");
    AST_INPUT_UNDRIVEN: assert property (@(posedge clock) disable iff (!reset_n)
        (!eff_dir[1]) |=> !pad.oe[1] && !pad.out[1] && !pad.reduced[1])
        else $error("input pin driven");
    AST_OUTPUT_LEVEL: assert property (@(posedge clock) disable iff (!reset_n)
        (eff_dir[2] && !analog_enable) |=> pad.oe[2] && pad.out[2] == $past(eff_out[2]))
        else $error("output level wrong");
    AST_PERIPH_DIR: assert property (@(posedge clock) disable iff (!reset_n)
        (periph_own[3] && !analog_enable) |=> pad.oe[3] == $past(periph_dir[3]))
        else $error("peripheral direction ignored");
    AST_ANALOG_OFF: assert property (@(posedge clock) disable iff (!reset_n)
        analog_enable |=> pad.oe == ppc_pkg::PPC_ZERO16 && input_read == ppc_pkg::PPC_ONES16)
        else $error("analog mode not honoured");
    AST_IRQ_OR: assert property (@(posedge clock) disable iff (!reset_n)
        irq_request == |(analog_port_edge_flags & analog_port_edge_enables))
        else $error("request mismatch");
    AST_SHORT_PULSE: assert property (@(posedge clock) disable iff (!reset_n)
        (!stop_mode && $rose(analog_port_edge_flags[0])) |->
        $past(g_irq.g_pin[0].active_lvl, 1) && $past(g_irq.g_pin[0].active_lvl, 2)
        && $past(g_irq.g_pin[0].active_lvl, 3) && $past(g_irq.g_pin[0].active_lvl, 4))
        else $error("flag set on short pulse");
    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        (analog_port_edge_flags[0] && !edge_event_flag_clear[0]) |=> analog_port_edge_flags[0])
        else $error("flag lost without clear");
    AST_READ_SETTLE: assert property (@(posedge clock) disable iff (!reset_n)
        (cfg.dir[4] && !cfg_we) [*2] |=> data_read[4] == $past(cfg.out_val[4]))
        else $error("output read wrong");

    AST_REDUCED_INPUT: assert property (@(posedge clock) disable iff (!reset_n)
        (!eff_dir[5]) |=> !pad.reduced[5])
        else $error("reduced drive on input pin");

    AST_PULL_SELECT: assert property (@(posedge clock) disable iff (!reset_n)
        (!eff_dir[6] && cfg.pull_device_on_bit[6]) |=>
        pad.pull_on[6] && pad.pull_down[6] == $past(cfg.polarity_choice_bit[6]))
        else $error("pull polarity wrong");

    AST_WIRED_OR_PULL: assert property (@(posedge clock) disable iff (!reset_n)
        (cfg.wired_or[8] && cfg.pull_device_on_bit[8]) |=> pad.pull_on[8])
        else $error("pull missing on wired-or output");

    AST_PERIPH_OUT: assert property (@(posedge clock) disable iff (!reset_n)
        (periph_own[3] && periph_dir[3] && !analog_enable) |=> pad.out[3] == $past(periph_out[3]))
        else $error("peripheral data ignored");

    AST_ANALOG_DATA: assert property (@(posedge clock) disable iff (!reset_n)
        analog_enable |=> (data_read | $past(cfg.dir)) == ppc_pkg::PPC_ONES16)
        else $error("analog input read not one");

    AST_DATA_INPUT: assert property (@(posedge clock) disable iff (!reset_n)
        (!cfg.dir[7] && !analog_enable) |=> data_read[7] == $past(sync_b[7]))
        else $error("input read not from pin");

    AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
        edge_event_enable_we[0] |=> analog_port_edge_enables[0] == $past(edge_event_enable_wdata[0]))
        else $error("edge enable write lost");

    AST_EDGE_POLARITY: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(analog_port_edge_flags[1]) |->
        $past(g_irq.g_pin[1].pin_src) == $past(cfg.polarity_choice_bit[1]))
        else $error("edge of wrong polarity");

    AST_FLAG_ON_EDGE: assert property (@(posedge clock) disable iff (!reset_n)
        g_irq.g_pin[1].valid_edge |=> analog_port_edge_flags[1])
        else $error("valid edge not flagged");

    // a clear only wins when no new edge lands in the same cycle
    AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
        (analog_port_edge_flags[0] && edge_event_flag_clear[0] && !g_irq.g_pin[0].valid_edge)
        |=> !analog_port_edge_flags[0])
        else $error("flag not cleared");

    AST_CNT_RANGE: assert property (@(posedge clock) disable iff (!reset_n)
        g_irq.g_pin[0].cnt < ppc_pkg::PPC_CNT_MAX)
        else $error("sample count out of range");

    AST_FILTER_FROZEN: assert property (@(posedge clock) disable iff (!reset_n)
        (stop_mode && !rc_tick) |=> $stable(g_irq.g_pin[0].cnt))
        else $error("filter advanced without rc tick");

    AST_RC_STOP_ONLY: assert property (@(posedge clock) disable iff (!reset_n)
        !stop_mode |-> !rc_osc_run)
        else $error("rc oscillator running outside stop");

    AST_RC_NEEDS_ENABLE: assert property (@(posedge clock) disable iff (!reset_n)
        rc_osc_run |-> |(analog_port_edge_enables & ~analog_port_edge_flags))
        else $error("rc oscillator running with nothing to watch");

    AST_IRQ_NEEDS_ENABLE: assert property (@(posedge clock) disable iff (!reset_n)
        irq_request |-> |analog_port_edge_enables)
        else $error("request without enable");

    AST_WAKE_FOLLOWS: assert property (@(posedge clock) disable iff (!reset_n)
        wake_request == irq_request)
        else $error("wake differs from request");

    COV_EDGE: cover property (@(posedge clock) disable iff (!reset_n) $rose(irq_request));
    COV_CLEAR: cover property (@(posedge clock) disable iff (!reset_n) $fell(analog_port_edge_flags[0]));
    COV_STOP_RC: cover property (@(posedge clock) disable iff (!reset_n) rc_osc_run ##1 !rc_osc_run);
    COV_ANALOG: cover property (@(posedge clock) disable iff (!reset_n) $rose(analog_enable));
    COV_STOP_WAKE: cover property (@(posedge clock) disable iff (!reset_n) stop_mode && $rose(wake_request));
endmodule : ppc_port
